/* hw/sacp_defs.vh */
`ifndef SACP_DEFS_VH
`define SACP_DEFS_VH

// Register byte addresses.
`define SACP_A_RXDATA     8'h00
`define SACP_A_TXDATA     8'h04
`define SACP_A_STATUS     8'h08
`define SACP_A_MTYPE      8'h0C
`define SACP_A_ACCRES_LIN 8'h10
`define SACP_A_ACCRES_STP 8'h14
`define SACP_A_CURRES     8'h18
`define SACP_A_MEMADDR    8'h1C

// Reset values.
`define SACP_RST_MTYPE    8'h55
`define SACP_RST_ACCRES   32'h00000000
`define SACP_RST_CURRES   32'h00000000

// Field positions.
`define SACP_TX_VALID_BIT 8
`define SACP_ST_TXV_BIT   8
`define SACP_ST_RXOK_BIT  9

// Characters.
`define SACP_CH_BANG  8'h21
`define SACP_CH_HASH  8'h23
`define SACP_CH_CR    8'h0D
`define SACP_CH_MINUS 8'h2D
`define SACP_CH_PLUS  8'h2B
`define SACP_CH_ZERO  8'h30
`define SACP_CH_NINE  8'h39
`define SACP_CH_A     8'h41
`define SACP_CH_D     8'h44
`define SACP_CH_Z     8'h5A

// Two-letter command codes.
`define SACP_GET_DEMAND_CURRENT_CMD   16'h4143
`define SACP_GET_ACCEL_RESOLUTION_CMD 16'h4149
`define SACP_SET_SEGMENT_OFFSET_CMD   16'h414F
`define SACP_SET_SEGMENT_NUMBER_CMD   16'h4153
`define SACP_CYCLIC_PROFILE_HERE_CMD  16'h4341
`define SACP_TRIGGERED_CYCLIC_HERE_CMD 16'h4342
`define SACP_QUERY_CURRENT_STEP_CMD   16'h4349

// Motor types, two bits per motor in the type register.
`define SACP_MT_NONE 2'h0
`define SACP_MT_LIN  2'h1
`define SACP_MT_STP  2'h2
`define SACP_MT_MAG  2'h3

// Argument limits.
`define SACP_ACC_LIM    17'h0199A
`define SACP_SEGOFF_MAX 17'h0FFFE
`define SACP_SEGNUM_MAX 17'h000FF
`define SACP_CURVE_MAX  17'h0FFFF

// Error characters sent between '#' and the carriage return.
`define SACP_ERR_NONE   8'h00
`define SACP_ERR_SYNTAX 8'h31
`define SACP_ERR_MOTOR  8'h32
`define SACP_ERR_BUSY   8'h33
`define SACP_ERR_RANGE  8'h34
`define SACP_ERR_CMD    8'h35

`endif

/* hw/sacp_buf2.v */
`default_nettype none
module sacp_buf2 #(
	parameter W = 8
) (
	input  wire         sys_clk,
	input  wire         resetn,
	input  wire [W-1:0] in_data,
	input  wire         in_valid,
	output wire         in_ready,
	output wire [W-1:0] out_data,
	output wire         out_valid,
	input  wire         out_ready
);
	reg [W-1:0] ent0_r;
	reg [W-1:0] ent1_r;
	reg [1:0]   cnt_r;
	reg         wp_r;
	reg         rp_r;
	wire        push = in_valid & in_ready;
	wire        pop  = out_valid & out_ready;

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = rp_r ? ent1_r : ent0_r;

	always @(posedge sys_clk) begin
		if (!resetn) begin
			ent0_r <= {W{1'b0}};
			ent1_r <= {W{1'b0}};
			cnt_r  <= 2'h0;
			wp_r   <= 1'b0;
			rp_r   <= 1'b0;
		end else begin
			if (push) begin
				if (wp_r)
					ent1_r <= in_data;
				else
					ent0_r <= in_data;
				wp_r <= ~wp_r;
			end
			if (pop)
				rp_r <= ~rp_r;
			if (push && !pop)
				cnt_r <= cnt_r + 2'h1;
			else if (pop && !push)
				cnt_r <= cnt_r - 2'h1;
		end
	end
endmodule // sacp_buf2
`default_nettype wire

/* hw/sacp_parser.v */
`include "sacp_defs.vh"
`default_nettype none
module sacp_parser (
	input  wire        sys_clk,
	input  wire        resetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [39:0] dem_cur,
	input  wire        trig,
	input  wire [3:0]  cyc_done,
	input  wire [3:0]  cyc_stop,
	output reg  [23:0] mem_addr_r,
	output reg  [3:0]  cyc_active_r,
	output reg         cyc_go_r,
	output reg  [1:0]  cyc_motor_r,
	output reg  [15:0] cyc_curve_r,
	output reg         cpo_load_r
);
	localparam [3:0] S_IDLE = 4'h0, S_C1 = 4'h1, S_C2 = 4'h2, S_ARG = 4'h3,
		S_EXEC = 4'h4, S_HASH = 4'h5, S_ERR = 4'h6, S_SIGN = 4'h7,
		S_DIV = 4'h8, S_DIG = 4'h9, S_CR = 4'hA;

	reg  [3:0]  st_r;
	reg  [15:0] cmd_r;
	reg  [16:0] acc_r;
	reg         neg_r;
	reg         bad_r;
	reg         ovf_r;
	reg         seen_r;
	reg  [7:0]  sel_r;
	reg  [7:0]  mtype_r;
	reg  [31:0] accres_lin_r;
	reg  [31:0] accres_stp_r;
	reg  [31:0] curres_r;
	reg         num_r;
	reg  [7:0]  err_r;
	reg  [31:0] val_r;
	reg         vneg_r;
	reg  [3:0]  pidx_r;
	reg  [3:0]  dig_r;
	reg         started_r;
	reg  [7:0]  txb_r;
	reg         txv_r;
	reg         trig_q_r;
	reg  [3:0]  arm_r;
	reg  [3:0]  stop_r;
	reg  [3:0]  gop_r;
	reg  [3:0]  here_r;
	reg  [15:0] curve_m [0:3];
	reg  [3:0]  act_nxt;
	reg  [3:0]  arm_nxt;
	reg  [3:0]  stop_nxt;
	reg  [3:0]  gop_nxt;
	reg  [3:0]  here_nxt;
	reg         svc;
	reg  [1:0]  svc_i;
	reg  [7:0]  ex_err;
	reg         ex_num;
	reg  [31:0] ex_val;
	reg         ex_neg;
	reg         ex_go;
	reg         ex_arm;
	reg         ex_off;
	reg         ex_seg;
	reg  [31:0] rd_mux;
	reg         rd_map;
	reg  [31:0] pw;
	integer     i;
	integer     j;

	wire        buf_rdy;
	wire [7:0]  tx_head;
	wire        tx_has;
	wire        apb_acc = psel & penable;
	wire        apb_done = apb_acc & pready;
	wire        rx_ok = (st_r <= S_ARG);
	wire        rx_wr = apb_done & pwrite & (paddr == `SACP_A_RXDATA);
	wire        tx_pop = apb_done & ~pwrite & (paddr == `SACP_A_TXDATA) &
		prdata[`SACP_TX_VALID_BIT];
	wire [7:0]  rxb = pwdata[7:0];
	wire [3:0]  rxd = rxb[3:0];
	wire [19:0] acc_mul = {acc_r, 3'b000} + {2'b00, acc_r, 1'b0} +
		{16'h0000, rxd};
	wire        sel_ok = seen_r && sel_r >= `SACP_CH_A &&
		sel_r <= `SACP_CH_D;
	wire [1:0]  mi = sel_r[1:0] - 2'h1;
	wire [1:0]  mt = mtype_r[{mi, 1'b0} +: 2];
	wire [5:0]  dcb = {1'b0, mi, 3'b000} + {3'b000, mi, 1'b0};
	wire [9:0]  dc = dem_cur[dcb +: 10];
	wire [9:0]  dc_mag = dc[9] ? (~dc + 10'h001) : dc;
	wire        tr_rise = trig & ~trig_q_r;
	wire        can = ~txv_r | buf_rdy;
	wire        do_exec = (st_r == S_EXEC);

	always @* begin
		case (pidx_r)
		4'h0: pw = 32'h00000001;
		4'h1: pw = 32'h0000000A;
		4'h2: pw = 32'h00000064;
		4'h3: pw = 32'h000003E8;
		4'h4: pw = 32'h00002710;
		4'h5: pw = 32'h000186A0;
		4'h6: pw = 32'h000F4240;
		4'h7: pw = 32'h00989680;
		4'h8: pw = 32'h05F5E100;
		default: pw = 32'h3B9ACA00;
		endcase
	end

	// Decides the outcome of a complete frame.
	always @* begin
		ex_err = `SACP_ERR_NONE;
		ex_num = 1'b0;
		ex_val = 32'h00000000;
		ex_neg = 1'b0;
		ex_go  = 1'b0;
		ex_arm = 1'b0;
		ex_off = 1'b0;
		ex_seg = 1'b0;
		if (bad_r)
			ex_err = `SACP_ERR_SYNTAX;
		else if (neg_r || ovf_r)
			ex_err = `SACP_ERR_RANGE;
		else begin
			case (cmd_r)
			`SACP_GET_DEMAND_CURRENT_CMD: begin
				if (!sel_ok || mt == `SACP_MT_NONE) begin
					ex_err = `SACP_ERR_MOTOR;
				end else begin
					ex_num = 1'b1;
					ex_val = {22'h00000, dc_mag};
					ex_neg = dc[9];
				end
			end
			`SACP_GET_ACCEL_RESOLUTION_CMD: begin
				ex_num = sel_ok;
				if (sel_ok && mt == `SACP_MT_LIN)
					ex_val = accres_lin_r;
				else if (sel_ok && mt == `SACP_MT_STP)
					ex_val = accres_stp_r;
				else begin
					ex_num = 1'b0;
					ex_err = `SACP_ERR_MOTOR;
				end
			end
			`SACP_QUERY_CURRENT_STEP_CMD: begin
				if (seen_r || acc_r != 17'h00001) begin
					ex_err = `SACP_ERR_SYNTAX;
				end else begin
					ex_num = 1'b1;
					ex_val = curres_r;
				end
			end
			`SACP_SET_SEGMENT_OFFSET_CMD: begin
				if (!sel_ok || mt == `SACP_MT_NONE)
					ex_err = `SACP_ERR_MOTOR;
				else if (acc_r > `SACP_SEGOFF_MAX || acc_r[0])
					ex_err = `SACP_ERR_RANGE;
				else
					ex_off = 1'b1;
			end
			`SACP_SET_SEGMENT_NUMBER_CMD: begin
				if (!sel_ok || mt == `SACP_MT_NONE)
					ex_err = `SACP_ERR_MOTOR;
				else if (acc_r > `SACP_SEGNUM_MAX)
					ex_err = `SACP_ERR_RANGE;
				else
					ex_seg = 1'b1;
			end
			`SACP_CYCLIC_PROFILE_HERE_CMD,
			`SACP_TRIGGERED_CYCLIC_HERE_CMD: begin
				if (!sel_ok || mt == `SACP_MT_NONE)
					ex_err = `SACP_ERR_MOTOR;
				else if (acc_r > `SACP_CURVE_MAX)
					ex_err = `SACP_ERR_RANGE;
				else if (cyc_active_r[mi] || arm_r[mi])
					ex_err = `SACP_ERR_BUSY;
				else if (cmd_r == `SACP_CYCLIC_PROFILE_HERE_CMD)
					ex_go = 1'b1;
				else
					ex_arm = 1'b1;
			end
			default: ex_err = `SACP_ERR_CMD;
			endcase
		end
	end

	// Per-motor cyclic profile bookkeeping; at most one start is issued per cycle, lowest-numbered pending motor first.
	always @* begin
		act_nxt  = cyc_active_r;
		arm_nxt  = arm_r;
		stop_nxt = stop_r;
		gop_nxt  = gop_r;
		here_nxt = here_r;
		svc      = |gop_r;
		svc_i    = 2'h0;
		for (i = 3; i >= 0; i = i - 1) begin
			if (gop_r[i])
				svc_i = i[1:0];
		end
		if (svc) begin
			gop_nxt[svc_i]  = 1'b0;
			here_nxt[svc_i] = 1'b0;
		end
		for (i = 0; i < 4; i = i + 1) begin
			if (cyc_done[i] && cyc_active_r[i] && stop_r[i]) begin
				act_nxt[i]  = 1'b0;
				stop_nxt[i] = 1'b0;
			end else if (cyc_done[i] && cyc_active_r[i]) begin
				gop_nxt[i] = 1'b1;
			end
			if (tr_rise && arm_r[i]) begin
				arm_nxt[i]  = 1'b0;
				act_nxt[i]  = 1'b1;
				gop_nxt[i]  = 1'b1;
				here_nxt[i] = 1'b1;
			end
			if (cyc_stop[i]) begin
				stop_nxt[i] = act_nxt[i];
				arm_nxt[i]  = 1'b0;
			end
		end
		if (do_exec && ex_go) begin
			act_nxt[mi]  = 1'b1;
			gop_nxt[mi]  = 1'b1;
			here_nxt[mi] = 1'b1;
		end
		if (do_exec && ex_arm)
			arm_nxt[mi] = 1'b1;
	end

	always @* begin
		rd_map = 1'b1;
		rd_mux = 32'h00000000;
		if (paddr == `SACP_A_RXDATA)
			rd_mux = 32'h00000000;
		else if (paddr == `SACP_A_TXDATA)
			rd_mux = {23'h00000, tx_has, tx_head};
		else if (paddr == `SACP_A_STATUS)
			rd_mux = {22'h00000, rx_ok, tx_has, arm_r, cyc_active_r};
		else if (paddr == `SACP_A_MTYPE)
			rd_mux = {24'h000000, mtype_r};
		else if (paddr == `SACP_A_ACCRES_LIN)
			rd_mux = accres_lin_r;
		else if (paddr == `SACP_A_ACCRES_STP)
			rd_mux = accres_stp_r;
		else if (paddr == `SACP_A_CURRES)
			rd_mux = curres_r;
		else if (paddr == `SACP_A_MEMADDR)
			rd_mux = {8'h00, mem_addr_r};
		else
			rd_map = 1'b0;
	end

	always @(posedge sys_clk) begin
		if (!resetn) begin
			prdata       <= 32'h00000000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			mtype_r      <= `SACP_RST_MTYPE;
			accres_lin_r <= `SACP_RST_ACCRES;
			accres_stp_r <= `SACP_RST_ACCRES;
			curres_r     <= `SACP_RST_CURRES;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			// A byte write waits while the previous frame is being answered.
			if (apb_acc && !pready &&
			    !(pwrite && paddr == `SACP_A_RXDATA && !rx_ok)) begin
				pready  <= 1'b1;
				prdata  <= rd_mux;
				pslverr <= ~rd_map;
			end
			if (apb_done && pwrite) begin
				if (paddr == `SACP_A_MTYPE)
					mtype_r <= pwdata[7:0];
				else if (paddr == `SACP_A_ACCRES_LIN)
					accres_lin_r <= pwdata;
				else if (paddr == `SACP_A_ACCRES_STP)
					accres_stp_r <= pwdata;
				else if (paddr == `SACP_A_CURRES)
					curres_r <= pwdata;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (!resetn) begin
			cyc_active_r <= 4'h0;
			arm_r        <= 4'h0;
			stop_r       <= 4'h0;
			gop_r        <= 4'h0;
			here_r       <= 4'h0;
			trig_q_r     <= 1'b0;
			cyc_go_r     <= 1'b0;
			cyc_motor_r  <= 2'h0;
			cyc_curve_r  <= 16'h0000;
			cpo_load_r   <= 1'b0;
			for (j = 0; j < 4; j = j + 1)
				curve_m[j] <= 16'h0000;
		end else begin
			cyc_active_r <= act_nxt;
			arm_r        <= arm_nxt;
			stop_r       <= stop_nxt;
			gop_r        <= gop_nxt;
			here_r       <= here_nxt;
			trig_q_r     <= trig;
			cyc_go_r     <= svc;
			cpo_load_r   <= svc & here_r[svc_i];
			if (svc) begin
				cyc_motor_r <= svc_i;
				cyc_curve_r <= curve_m[svc_i];
			end
			if (do_exec && (ex_go || ex_arm))
				curve_m[mi] <= acc_r[15:0];
		end
	end

	// Frame parser and reply generator.
	always @(posedge sys_clk) begin
		if (!resetn) begin
			st_r       <= S_IDLE;
			cmd_r      <= 16'h0000;
			acc_r      <= 17'h00000;
			neg_r      <= 1'b0;
			bad_r      <= 1'b0;
			ovf_r      <= 1'b0;
			seen_r     <= 1'b0;
			sel_r      <= 8'h00;
			mem_addr_r <= 24'h000000;
			num_r      <= 1'b0;
			err_r      <= 8'h00;
			val_r      <= 32'h00000000;
			vneg_r     <= 1'b0;
			pidx_r     <= 4'h0;
			dig_r      <= 4'h0;
			started_r  <= 1'b0;
			txb_r      <= 8'h00;
			txv_r      <= 1'b0;
		end else begin
			if (buf_rdy)
				txv_r <= 1'b0;
			case (st_r)
			S_IDLE: begin
				if (rx_wr && rxb == `SACP_CH_BANG) begin
					st_r   <= S_C1;
					acc_r  <= 17'h00000;
					neg_r  <= 1'b0;
					bad_r  <= 1'b0;
					ovf_r  <= 1'b0;
					seen_r <= 1'b0;
				end
			end
			S_C1, S_C2: begin
				if (rx_wr && rxb == `SACP_CH_CR) begin
					bad_r <= 1'b1;
					st_r  <= S_EXEC;
				end else if (rx_wr) begin
					cmd_r <= {cmd_r[7:0], rxb};
					st_r  <= (st_r == S_C1) ? S_C2 : S_ARG;
				end
			end
			S_ARG: begin
				if (rx_wr) begin
					if (rxb == `SACP_CH_CR)
						st_r <= S_EXEC;
					else if (rxb >= `SACP_CH_ZERO &&
					         rxb <= `SACP_CH_NINE) begin
						if (acc_r >= `SACP_ACC_LIM)
							ovf_r <= 1'b1;
						else
							acc_r <= acc_mul[16:0];
					end else if (rxb == `SACP_CH_MINUS)
						neg_r <= 1'b1;
					else if (rxb >= `SACP_CH_A &&
					         rxb <= `SACP_CH_Z) begin
						sel_r  <= rxb;
						seen_r <= 1'b1;
					end else if (rxb != `SACP_CH_PLUS)
						bad_r <= 1'b1;
				end
			end
			S_EXEC: begin
				if (ex_off)
					mem_addr_r[15:0] <= acc_r[15:0];
				if (ex_seg)
					mem_addr_r[23:16] <= acc_r[7:0];
				num_r  <= ex_num;
				err_r  <= ex_err;
				val_r  <= ex_val;
				vneg_r <= ex_neg;
				st_r   <= S_HASH;
			end
			S_HASH: begin
				if (can) begin
					txb_r     <= `SACP_CH_HASH;
					txv_r     <= 1'b1;
					pidx_r    <= 4'h9;
					dig_r     <= 4'h0;
					started_r <= 1'b0;
					if (num_r)
						st_r <= vneg_r ? S_SIGN : S_DIV;
					else
						st_r <= (err_r != `SACP_ERR_NONE) ? S_ERR : S_CR;
				end
			end
			S_ERR: begin
				if (can) begin
					txb_r <= err_r;
					txv_r <= 1'b1;
					st_r  <= S_CR;
				end
			end
			S_SIGN: begin
				if (can) begin
					txb_r <= `SACP_CH_MINUS;
					txv_r <= 1'b1;
					st_r  <= S_DIV;
				end
			end
			S_DIV: begin
				if (val_r >= pw) begin
					val_r <= val_r - pw;
					dig_r <= dig_r + 4'h1;
				end else
					st_r <= S_DIG;
			end
			S_DIG: begin
				if (dig_r == 4'h0 && !started_r && pidx_r != 4'h0) begin
					pidx_r <= pidx_r - 4'h1;
					st_r   <= S_DIV;
				end else if (can) begin
					txb_r     <= `SACP_CH_ZERO | {4'h0, dig_r};
					txv_r     <= 1'b1;
					started_r <= 1'b1;
					dig_r     <= 4'h0;
					pidx_r    <= pidx_r - 4'h1;
					st_r      <= (pidx_r == 4'h0) ? S_CR : S_DIV;
				end
			end
			S_CR: begin
				if (can) begin
					txb_r <= `SACP_CH_CR;
					txv_r <= 1'b1;
					st_r  <= S_IDLE;
				end
			end
			default: st_r <= S_IDLE;
			endcase
		end
	end

	sacp_buf2 #(
		.W(8)
	) u_txbuf (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_data   (txb_r),
		.in_valid  (txv_r),
		.in_ready  (buf_rdy),
		.out_data  (tx_head),
		.out_valid (tx_has),
		.out_ready (tx_pop)
	);
endmodule // sacp_parser
`default_nettype wire

/* bench/sacp_parser_monitor.sv */
`default_nettype none
module sacp_parser_mon (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [39:0] dem_cur,
	input wire logic        trig,
	input wire logic [3:0]  cyc_done,
	input wire logic [3:0]  cyc_stop,
	input wire logic [23:0] mem_addr_r,
	input wire logic [3:0]  cyc_active_r,
	input wire logic        cyc_go_r,
	input wire logic [1:0]  cyc_motor_r,
	input wire logic [15:0] cyc_curve_r,
	input wire logic        cpo_load_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic acc_q;
	assign acc_q = psel && penable && pready;
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready stayed high");
	wait_state_a: assert property (
		psel && penable && !pready && paddr != 8'h00 |=> pready)
		else $error("missing single wait state");
	err_map_a: assert property (
		acc_q |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
		else $error("slave error does not match address");
	addr_read_a: assert property (
		acc_q && !pwrite && paddr == 8'h1C |-> prdata == {8'h00, mem_addr_r})
		else $error("address read differs from address output");
	offset_even_a: assert property (mem_addr_r[0] == 1'b0)
		else $error("odd segment offset");
	go_active_a: assert property (
		cyc_go_r |=> cyc_active_r[$past(cyc_motor_r)])
		else $error("profile start on inactive motor");
	offset_load_a: assert property (cpo_load_r |-> cyc_go_r)
		else $error("offset load without start");
	go_latch_a: assert property (
		$changed(cyc_curve_r) || $changed(cyc_motor_r) |-> cyc_go_r)
		else $error("curve or motor changed without start");
	stop_end_a: assert property (
		$fell(cyc_active_r[0]) |-> $past(cyc_done[0]) || $past(cyc_done[0], 2))
		else $error("cyclic run ended without a finished pass");
	cover property (cpo_load_r);
	cover property (acc_q && pslverr);
	cover property ($fell(cyc_active_r[1]));
endmodule // sacp_parser_mon
bind sacp_parser sacp_parser_mon u_sacp_parser_mon (
	.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dem_cur(dem_cur), .trig(trig),
	.cyc_done(cyc_done), .cyc_stop(cyc_stop), .mem_addr_r(mem_addr_r),
	.cyc_active_r(cyc_active_r), .cyc_go_r(cyc_go_r),
	.cyc_motor_r(cyc_motor_r), .cyc_curve_r(cyc_curve_r),
	.cpo_load_r(cpo_load_r));
`default_nettype wire

/* bench/sacp_drive_model.sv */
`default_nettype none
module sacp_drive_model #(
	parameter int DLY = 20
) (
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire logic       go,
	input  wire logic [1:0] motor,
	output var  logic [3:0] done
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt [4];
	// Each started pass runs DLY cycles, then reports one finished pass.
	always @(posedge sys_clk) begin
		for (int k = 0; k < 4; k++) begin
			done[k] <= 1'b0;
			if (!resetn) begin
				cnt[k] <= 0;
			end else if (go && motor == k[1:0]) begin
				cnt[k] <= DLY;
			end else if (cnt[k] == 1) begin
				cnt[k] <= 0;
				done[k] <= 1'b1;
			end else if (cnt[k] > 1) begin
				cnt[k] <= cnt[k] - 1;
			end
		end
	end
endmodule // sacp_drive_model
`default_nettype wire

/* bench/sacp_parser_tb.sv */
`default_nettype none
`define CHK(what, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("wrong value %s expected %0h seen %0h", \
				what, exp, got); \
		end \
	end
module sacp_parser_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic        trig, cyc_go_r, cpo_load_r, re, go_cpo;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rq;
	logic [39:0] dem_cur;
	logic [3:0]  cyc_done, cyc_stop, cyc_active_r;
	logic [23:0] mem_addr_r;
	logic [1:0]  cyc_motor_r, go_motor;
	logic [15:0] cyc_curve_r, go_curve;
	int          n_mismatch, check_count, n_go, n_base;

	sacp_parser u_sacp_parser (
		.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dem_cur(dem_cur), .trig(trig),
		.cyc_done(cyc_done), .cyc_stop(cyc_stop), .mem_addr_r(mem_addr_r),
		.cyc_active_r(cyc_active_r), .cyc_go_r(cyc_go_r),
		.cyc_motor_r(cyc_motor_r), .cyc_curve_r(cyc_curve_r),
		.cpo_load_r(cpo_load_r));
	sacp_drive_model #(.DLY(20)) u_sacp_drive_model (
		.sys_clk(sys_clk), .resetn(resetn), .go(cyc_go_r),
		.motor(cyc_motor_r), .done(cyc_done));

	always #25 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		if (cyc_go_r === 1'b1) begin
			n_go <= n_go + 1;
			go_motor <= cyc_motor_r;
			go_curve <= cyc_curve_r;
			go_cpo <= cpo_load_r;
		end
	end

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 2000);
		if (n >= 2000) n_mismatch++;
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// The whole reply is collected before the next command starts.
	task automatic cmd(input string c, input string r);
		logic [7:0] got [$];
		string      exp;
		int         i;
		int         n;
		exp = {"#", r, "\r"};
		for (i = 0; i < c.len(); i++) apb(1'b1, 8'h00, {24'h0, c[i]});
		apb(1'b1, 8'h00, 32'h0000000D);
		n = 0;
		while (n < 300 && (got.size() == 0 || got[$] !== 8'h0D)) begin
			apb(1'b0, 8'h04, 32'h0);
			if (rq[8] === 1'b1) got.push_back(rq[7:0]);
			n++;
		end
		`CHK(c, exp.len(), got.size());
		for (i = 0; i < exp.len() && i < got.size(); i++)
			`CHK(c, exp[i], got[i]);
	endtask

	// Waits until the count of starts differs from the given baseline.
	task automatic wait_go(input int n0);
		int n;
		n = 0;
		while (n_go == n0 && n < 500) begin
			@(posedge sys_clk);
			n++;
		end
		if (n_go == n0) n_mismatch++;
	endtask

	task automatic stop_wait(input logic [3:0] m);
		int n;
		cyc_stop <= m;
		@(posedge sys_clk);
		cyc_stop <= 4'h0;
		n = 0;
		while ((cyc_active_r & m) !== 4'h0 && n < 500) begin
			@(posedge sys_clk);
			n++;
		end
		`CHK("active cleared", 4'h0, cyc_active_r & m);
		n = n_go;
		repeat (60) @(posedge sys_clk);
		`CHK("no restart", n, n_go);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// About 1100 cycles are needed; allow well over ten times that.
	initial begin
		#1000000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		trig = 1'b0;
		cyc_stop = 4'h0;
		dem_cur = {10'h000, 10'h000, 10'h100, 10'h300};
		n_mismatch = 0;
		check_count = 0;
		n_go = 0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, 8'h0C, 32'h0);
		`CHK("motor types", 32'h00000055, rq);
		apb(1'b0, 8'h1C, 32'h0);
		`CHK("address", 32'h00000000, rq);
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 1'b1, re);
		apb(1'b1, 8'h0C, 32'h000000C9);
		apb(1'b1, 8'h10, 32'd238419);
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		apb(1'b1, 8'h18, 32'd23438);
		cmd("!AIA", "238419");
		cmd("!AIB", "4294967295");
		cmd("!AIC", "2");
		cmd("!AID", "2");
		cmd("!ACA", "-256");
		cmd("!ACB", "256");
		cmd("!ACD", "0");
		cmd("!CI1", "23438");
		cmd("!AO65534A", "");
		cmd("!AO3A", "4");
		cmd("!AS255D", "");
		cmd("!AS1C", "2");
		cmd("!AS256A", "4");
		cmd("!AS7E", "2");
		cmd("!ZZA", "5");
		apb(1'b0, 8'h1C, 32'h0);
		`CHK("address", 32'h00FFFFFE, rq);
		n_base = n_go;
		cmd("!CA5A", "");
		wait_go(n_base);
		`CHK("first motor", 2'h0, go_motor);
		`CHK("first curve", 16'h0005, go_curve);
		`CHK("first offset", 1'b1, go_cpo);
		wait_go(n_go);
		`CHK("restart", {2'h0, 1'b0}, {go_motor, go_cpo});
		cmd("!CA1A", "3");
		apb(1'b0, 8'h08, 32'h0);
		`CHK("active A", 4'h1, rq[3:0]);
		stop_wait(4'h1);
		cmd("!CB65535B", "");
		apb(1'b0, 8'h08, 32'h0);
		`CHK("armed B", 8'h20, rq[7:0]);
		trig <= 1'b1;
		wait_go(n_go);
		`CHK("trigger motor", 2'h1, go_motor);
		`CHK("trigger curve", 16'hFFFF, go_curve);
		`CHK("trigger offset", 1'b1, go_cpo);
		trig <= 1'b0;
		stop_wait(4'h2);
		print_verdict();
	end
endmodule // sacp_parser_tb
`default_nettype wire
